// ==== hw/cprf_consts.vh ====
// constants for the cpu programmer register file
`ifndef CPRF_CONSTS_VH
`define CPRF_CONSTS_VH
`define CPRF_OFS_ACC    8'h00
`define CPRF_OFS_INDEX  8'h04
`define CPRF_OFS_SP     8'h08
`define CPRF_OFS_PC     8'h0C
`define CPRF_OFS_CCR    8'h10
`define CPRF_OFS_CMD    8'h14
`define CPRF_OFS_STAT   8'h18
`define CPRF_OFS_EA     8'h1C
`define CPRF_OFS_DATA   8'h20
`define CPRF_SP_RST     16'h00FF
`define CPRF_SP_LO_RST  8'hFF
`define CPRF_VEC_RESET  16'hFFFE
`define CPRF_VEC_SWI    16'hFFFC
`define CPRF_VEC_IRQ0   16'hFFFA
`define CPRF_CCR_ONES   8'h60
`define CPRF_CCR_RST    8'h68
`define CPRF_B_V        7
`define CPRF_B_H        4
`define CPRF_B_I        3
`define CPRF_B_N        2
`define CPRF_B_Z        1
`define CPRF_B_C        0
`define CPRF_IRQ_BYTES  3'd5
`define CPRF_CALL_BYTES 3'd2
`define CPRF_C_NOP      4'h0
`define CPRF_C_ALU      4'h1
`define CPRF_C_FETCH    4'h2
`define CPRF_C_JUMP     4'h3
`define CPRF_C_BRANCH   4'h4
`define CPRF_C_SPLO     4'h5
`define CPRF_C_UNMASK   4'h6
`define CPRF_C_CALL     4'h7
`define CPRF_C_RET      4'h8
`define CPRF_C_SWI      4'h9
`define CPRF_C_IRET     4'hA
`define CPRF_C_PSHA     4'hB
`define CPRF_C_PULA     4'hC
`define CPRF_C_PUSHX    4'hD
`define CPRF_C_PULLX    4'hE
`define CPRF_C_EA       4'hF
`define CPRF_A_ADD      4'h0
`define CPRF_A_ADC      4'h1
`define CPRF_A_SUB      4'h2
`define CPRF_A_SBC      4'h3
`define CPRF_A_AND      4'h4
`define CPRF_A_ORA      4'h5
`define CPRF_A_EOR      4'h6
`define CPRF_A_LSL      4'h7
`define CPRF_A_LSR      4'h8
`define CPRF_A_ROL      4'h9
`define CPRF_A_ROR      4'hA
`define CPRF_A_DECADJ   4'hB
`define CPRF_A_LDA      4'hC
`define CPRF_A_CMP      4'hD
`define CPRF_BR_ALW     4'h0
`define CPRF_BR_GE      4'h1
`define CPRF_BR_LT      4'h2
`define CPRF_BR_GT      4'h3
`define CPRF_BR_LE      4'h4
`endif

// ==== hw/cprf_alu.v ====
// eight-bit arithmetic/logic unit with condition flag generation
`timescale 1ns/1ps
`include "cprf_consts.vh"
module cprf_alu (
	// operands
	input  wire [3:0] op_i,
	input  wire [7:0] a_i,
	input  wire [7:0] b_i,
	input  wire [7:0] ccr_i,
	// results
	output reg  [7:0] res_o,
	output reg  [7:0] ccr_o
);
	reg [8:0] sum;
	reg [4:0] low;
	reg       cin;
	reg [7:0] corr;
	always @* begin
		cin = ccr_i[`CPRF_B_C];
		sum = 9'h000;
		low = 5'h00;
		corr = 8'h00;
		res_o = a_i;
		ccr_o = ccr_i;
		case (op_i)
			`CPRF_A_ADD, `CPRF_A_ADC: begin
				if (op_i == `CPRF_A_ADD)
					cin = 1'b0;
				sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
				low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
				res_o = sum[7:0];
				ccr_o[`CPRF_B_C] = sum[8];
				ccr_o[`CPRF_B_H] = low[4];
				ccr_o[`CPRF_B_V] = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
			end
			`CPRF_A_SUB, `CPRF_A_SBC, `CPRF_A_CMP: begin
				if (op_i != `CPRF_A_SBC)
					cin = 1'b0;
				sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
				res_o = (op_i == `CPRF_A_CMP) ? a_i : sum[7:0];
				ccr_o[`CPRF_B_C] = sum[8];
				ccr_o[`CPRF_B_V] = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
			end
			`CPRF_A_AND: res_o = a_i & b_i;
			`CPRF_A_ORA: res_o = a_i | b_i;
			`CPRF_A_EOR: res_o = a_i ^ b_i;
			`CPRF_A_LDA: res_o = b_i;
			`CPRF_A_LSL, `CPRF_A_ROL: begin
				res_o = {a_i[6:0], (op_i == `CPRF_A_ROL) ? cin : 1'b0};
				ccr_o[`CPRF_B_C] = a_i[7];
			end
			`CPRF_A_LSR, `CPRF_A_ROR: begin
				res_o = {(op_i == `CPRF_A_ROR) ? cin : 1'b0, a_i[7:1]};
				ccr_o[`CPRF_B_C] = a_i[0];
			end
			`CPRF_A_DECADJ: begin
				// correction chosen from half-carry and carry
				if (ccr_i[`CPRF_B_C] || a_i > 8'h99) begin
					corr[6:5] = 2'b11;
					ccr_o[`CPRF_B_C] = 1'b1;
				end
				if (ccr_i[`CPRF_B_H] || a_i[3:0] > 4'h9)
					corr[2:1] = 2'b11;
				res_o = a_i + corr;
			end
			default: res_o = a_i;
		endcase
		// logic ops clear overflow, shifts set it from n xor c
		if (op_i == `CPRF_A_AND || op_i == `CPRF_A_ORA || op_i == `CPRF_A_EOR || op_i == `CPRF_A_LDA)
			ccr_o[`CPRF_B_V] = 1'b0;
		if (op_i >= `CPRF_A_LSL && op_i <= `CPRF_A_ROR)
			ccr_o[`CPRF_B_V] = res_o[7] ^ ccr_o[`CPRF_B_C];
		ccr_o[`CPRF_B_N] = res_o[7];
		ccr_o[`CPRF_B_Z] = (op_i == `CPRF_A_CMP) ? (sum[7:0] == 8'h00) : (res_o == 8'h00);
		if (op_i == `CPRF_A_CMP)
			ccr_o[`CPRF_B_N] = sum[7];
	end
endmodule // cprf_alu

// ==== hw/cprf_axil.v ====
// axi4-lite slave front end producing register strobes
`timescale 1ns/1ps
module cprf_axil (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	// axi4-lite
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// register side
	output wire        wr_en_o,
	output reg  [7:0]  wr_addr_o,
	output reg  [31:0] wr_data_o,
	output reg  [3:0]  wr_strb_o,
	input  wire        wr_err_i,
	input  wire [31:0] rd_data_i,
	input  wire        rd_err_i
);
	reg aw_full_reg;
	reg w_full_reg;
	assign s_axi_awready_o = ce_i & ~aw_full_reg;
	assign s_axi_wready_o  = ce_i & ~w_full_reg;
	assign s_axi_arready_o = ce_i & ~s_axi_rvalid_o;
	assign wr_en_o         = ce_i & aw_full_reg & w_full_reg & ~s_axi_bvalid_o;
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 32'h0000_0000;
			wr_strb_o <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= 2'b00;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= 2'b00;
			s_axi_rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				wr_addr_o <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && !w_full_reg) begin
				w_full_reg <= 1'b1;
				wr_data_o <= s_axi_wdata_i;
				wr_strb_o <= s_axi_wstrb_i;
			end
			if (wr_en_o) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_err_i ? 2'b10 : 2'b00;
			end else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_data_i;
				s_axi_rresp_o <= rd_err_i ? 2'b10 : 2'b00;
			end else if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end
endmodule // cprf_axil

// ==== hw/cprf_core.v ====
// cpu programmer register file with stack and vector sequencer
//
// Contract
// - eight-bit accumulator holds operands and results
// - sixteen-bit index made of high and low byte
// - indexed addressing uses index register contents
// - stack pointer resets to 00FF
// - stack reset instruction sets low byte FF
// - push decrements, pull increments stack pointer
// - stack relative modes use stack pointer base
// - program counter steps on fetch, jumps load
// - reset loads program counter from FFFE/FFFF
// - condition bits six and five read one
// - overflow flag on signed overflow, signed branches
// - half carry from bit three; decimal adjust
// - mask set ignores maskable interrupt requests
// - interrupt: stack, then mask, then vector
// - interrupt entry never stacks index high byte
// - highest priority pending request served first
// - return from interrupt pulls registers and mask
// - reset sets mask; clear instruction or return from interrupt clears
// - negative flag copies result bit seven
// - zero flag set on zero result
// - carry on add carry, borrow, shifts
// - interrupt stacks five bytes, call two
`timescale 1ns/1ps
`include "cprf_consts.vh"
module cprf_core (
	// clock, reset, enable
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	// axi4-lite register bus
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output wire [1:0]  s_axi_bresp_o,
	output wire        s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0]  s_axi_rresp_o,
	output wire        s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// internal memory bus
	output reg         mem_req_o,
	output reg         mem_we_o,
	output reg  [15:0] mem_addr_o,
	output reg  [7:0]  mem_wdata_o,
	input  wire [7:0]  mem_rdata_i,
	input  wire        mem_ack_i,
	// interrupt request pins, bit 0 highest priority
	input  wire [7:0]  irq_i,
	// state
	output wire        busy_o,
	output wire        mask_o
);
	localparam [5:0] S_IDLE  = 6'h01;
	localparam [5:0] S_PUSH  = 6'h02;
	localparam [5:0] S_PULL  = 6'h04;
	localparam [5:0] S_VECH  = 6'h08;
	localparam [5:0] S_VECL  = 6'h10;
	localparam [5:0] S_FETCH = 6'h20;

	reg  [7:0]  accumulator_reg;
	reg  [15:0] index_pair_reg;
	reg  [15:0] stack_pointer_reg;
	reg  [15:0] program_counter_reg;
	reg  [7:0]  condition_code_reg;
	reg  [15:0] eaddr_reg;
	reg  [7:0]  data_reg;
	reg  [5:0]  st_reg;
	reg  [3:0]  kind_reg;
	reg  [2:0]  cnt_reg;
	reg  [15:0] tgt_reg;
	reg  [15:0] vec_reg;
	reg  [7:0]  irq_meta_reg;
	reg  [7:0]  irq_sync_reg;

	wire        wr_en;
	wire [7:0]  wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	reg         wr_err;
	reg  [31:0] rd_data;
	reg         rd_err;
	wire [7:0]  alu_res;
	wire [7:0]  alu_ccr;
	wire [3:0]  cmd       = wr_data[3:0];
	wire [3:0]  sub       = wr_data[7:4];
	wire [15:0] operand   = wr_data[23:8];
	wire        idle      = st_reg == S_IDLE;
	wire        cmd_go    = wr_en && idle && wr_addr == `CPRF_OFS_CMD && wr_strb[0];
	wire [7:0]  ccr_view  = condition_code_reg | `CPRF_CCR_ONES;
	wire        sgn_lt    = ccr_view[`CPRF_B_N] ^ ccr_view[`CPRF_B_V];
	wire [7:0]  irq_pend  = irq_sync_reg;
	wire        irq_go    = idle && !cmd_go && !ccr_view[`CPRF_B_I] && |irq_pend;
	reg  [2:0]  irq_num;
	reg         br_take;
	reg  [7:0]  push_byte;
	reg  [15:0] mem_addr_sel;
	integer     i;

	assign busy_o = !idle;
	assign mask_o = ccr_view[`CPRF_B_I];

	// bytes moved by a stack sequence
	function [2:0] seq_len;
		input [3:0] k;
		begin
			case (k)
				`CPRF_C_SWI, `CPRF_C_IRET: seq_len = `CPRF_IRQ_BYTES;
				`CPRF_C_CALL, `CPRF_C_RET: seq_len = `CPRF_CALL_BYTES;
				default: seq_len = 3'd1;
			endcase
		end
	endfunction

	// merge byte lanes of a write into a 16-bit register
	function [15:0] lane16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  strb;
		begin
			lane16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	cprf_axil u_axil (
		.clk_sys_i       (clk_sys_i),
		.sys_rst_i       (sys_rst_i),
		.ce_i            (ce_i),
		.s_axi_awaddr_i  (s_axi_awaddr_i),
		.s_axi_awvalid_i (s_axi_awvalid_i),
		.s_axi_awready_o (s_axi_awready_o),
		.s_axi_wdata_i   (s_axi_wdata_i),
		.s_axi_wstrb_i   (s_axi_wstrb_i),
		.s_axi_wvalid_i  (s_axi_wvalid_i),
		.s_axi_wready_o  (s_axi_wready_o),
		.s_axi_bresp_o   (s_axi_bresp_o),
		.s_axi_bvalid_o  (s_axi_bvalid_o),
		.s_axi_bready_i  (s_axi_bready_i),
		.s_axi_araddr_i  (s_axi_araddr_i),
		.s_axi_arvalid_i (s_axi_arvalid_i),
		.s_axi_arready_o (s_axi_arready_o),
		.s_axi_rdata_o   (s_axi_rdata_o),
		.s_axi_rresp_o   (s_axi_rresp_o),
		.s_axi_rvalid_o  (s_axi_rvalid_o),
		.s_axi_rready_i  (s_axi_rready_i),
		.wr_en_o         (wr_en),
		.wr_addr_o       (wr_addr),
		.wr_data_o       (wr_data),
		.wr_strb_o       (wr_strb),
		.wr_err_i        (wr_err),
		.rd_data_i       (rd_data),
		.rd_err_i        (rd_err)
	);

	cprf_alu u_alu (
		.op_i  (sub),
		.a_i   (accumulator_reg),
		.b_i   (operand[7:0]),
		.ccr_i (ccr_view),
		.res_o (alu_res),
		.ccr_o (alu_ccr)
	);

	// register read mux and address decode
	always @* begin
		rd_err = 1'b0;
		rd_data = 32'h0000_0000;
		case ({s_axi_araddr_i[7:2], 2'b00})
			`CPRF_OFS_ACC:   rd_data[7:0] = accumulator_reg;
			`CPRF_OFS_INDEX: rd_data[15:0] = index_pair_reg;
			`CPRF_OFS_SP:    rd_data[15:0] = stack_pointer_reg;
			`CPRF_OFS_PC:    rd_data[15:0] = program_counter_reg;
			`CPRF_OFS_CCR:   rd_data[7:0] = ccr_view;
			`CPRF_OFS_CMD:   rd_data = 32'h0000_0000;
			`CPRF_OFS_STAT:  rd_data[17:0] = {irq_pend, 8'h00, mask_o, busy_o};
			`CPRF_OFS_EA:    rd_data[15:0] = eaddr_reg;
			`CPRF_OFS_DATA:  rd_data[7:0] = data_reg;
			default:         rd_err = 1'b1;
		endcase
		wr_err = ({wr_addr[7:2], 2'b00} > `CPRF_OFS_DATA) || (wr_addr[7:2] == `CPRF_OFS_STAT >> 2);
	end

	// priority pick, stacked bytes, branch condition, bus address
	always @* begin
		irq_num = 3'd0;
		for (i = 7; i >= 0; i = i - 1)
			if (irq_pend[i])
				irq_num = i[2:0];
		case (sub)
			`CPRF_BR_GE: br_take = !sgn_lt;
			`CPRF_BR_LT: br_take = sgn_lt;
			`CPRF_BR_GT: br_take = !(ccr_view[`CPRF_B_Z] | sgn_lt);
			`CPRF_BR_LE: br_take = ccr_view[`CPRF_B_Z] | sgn_lt;
			default:     br_take = 1'b1;
		endcase
		// the index high byte is never part of the entry frame
		case ({kind_reg, cnt_reg})
			{`CPRF_C_SWI, 3'd1}, {`CPRF_C_CALL, 3'd1}: push_byte = program_counter_reg[15:8];
			{`CPRF_C_SWI, 3'd2}: push_byte = index_pair_reg[7:0];
			{`CPRF_C_SWI, 3'd3}, {`CPRF_C_PSHA, 3'd0}: push_byte = accumulator_reg;
			{`CPRF_C_SWI, 3'd4}: push_byte = ccr_view;
			{`CPRF_C_PUSHX, 3'd0}: push_byte = index_pair_reg[15:8];
			default: push_byte = program_counter_reg[7:0];
		endcase
		case (st_reg)
			S_PUSH:  mem_addr_sel = stack_pointer_reg;
			S_PULL:  mem_addr_sel = stack_pointer_reg + 16'h0001;
			S_VECH:  mem_addr_sel = vec_reg;
			S_VECL:  mem_addr_sel = vec_reg + 16'h0001;
			default: mem_addr_sel = program_counter_reg;
		endcase
	end

	// request pins come from outside the clock domain
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_meta_reg <= 8'h00;
			irq_sync_reg <= 8'h00;
		end else if (ce_i) begin
			irq_meta_reg <= irq_i;
			irq_sync_reg <= irq_meta_reg;
		end
	end

	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			accumulator_reg <= 8'h00;
			index_pair_reg <= 16'h0000;
			stack_pointer_reg <= `CPRF_SP_RST;
			program_counter_reg <= 16'h0000;
			condition_code_reg <= `CPRF_CCR_RST;
			eaddr_reg <= 16'h0000;
			data_reg <= 8'h00;
			st_reg <= S_VECH;
			vec_reg <= `CPRF_VEC_RESET;
			kind_reg <= `CPRF_C_NOP;
			cnt_reg <= 3'd0;
			tgt_reg <= 16'h0000;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
		end else if (ce_i) begin
			// direct register writes only while the sequencer rests
			if (wr_en && idle) begin
				case ({wr_addr[7:2], 2'b00})
					`CPRF_OFS_ACC: if (wr_strb[0])
						accumulator_reg <= wr_data[7:0];
					`CPRF_OFS_INDEX: index_pair_reg <= lane16(index_pair_reg, wr_data[15:0], wr_strb[1:0]);
					`CPRF_OFS_SP: stack_pointer_reg <= lane16(stack_pointer_reg, wr_data[15:0], wr_strb[1:0]);
					`CPRF_OFS_PC: program_counter_reg <= lane16(program_counter_reg, wr_data[15:0], wr_strb[1:0]);
					`CPRF_OFS_CCR: if (wr_strb[0])
						// a plain write may set the mask but never clear it
						condition_code_reg <= wr_data[7:0] | `CPRF_CCR_ONES | (ccr_view & 8'h08);
					default: ;
				endcase
			end
			if (cmd_go) begin
				kind_reg <= cmd;
				cnt_reg <= 3'd0;
				case (cmd)
					`CPRF_C_ALU: begin
						if (sub != `CPRF_A_CMP)
							accumulator_reg <= alu_res;
						condition_code_reg <= alu_ccr | `CPRF_CCR_ONES;
					end
					`CPRF_C_FETCH: st_reg <= S_FETCH;
					`CPRF_C_JUMP: program_counter_reg <= operand;
					`CPRF_C_BRANCH: if (br_take)
						program_counter_reg <= program_counter_reg + {{8{operand[7]}}, operand[7:0]};
					`CPRF_C_SPLO: stack_pointer_reg[7:0] <= `CPRF_SP_LO_RST;
					`CPRF_C_UNMASK: condition_code_reg[`CPRF_B_I] <= 1'b0;
					`CPRF_C_CALL: begin
						tgt_reg <= operand;
						st_reg <= S_PUSH;
					end
					`CPRF_C_SWI: begin
						vec_reg <= `CPRF_VEC_SWI;
						st_reg <= S_PUSH;
					end
					`CPRF_C_PSHA, `CPRF_C_PUSHX: st_reg <= S_PUSH;
					`CPRF_C_RET, `CPRF_C_IRET, `CPRF_C_PULA, `CPRF_C_PULLX: st_reg <= S_PULL;
					`CPRF_C_EA: eaddr_reg <= (sub[0] ? stack_pointer_reg : index_pair_reg) + operand;
					default: ;
				endcase
			end else if (irq_go) begin
				// hardware entry shares the software interrupt frame
				kind_reg <= `CPRF_C_SWI;
				cnt_reg <= 3'd0;
				vec_reg <= `CPRF_VEC_IRQ0 - {12'h000, irq_num, 1'b0};
				st_reg <= S_PUSH;
			end
			// memory side: one byte per request, request held until ack
			if (!idle && !mem_req_o) begin
				mem_req_o <= 1'b1;
				mem_we_o <= st_reg == S_PUSH;
				mem_addr_o <= mem_addr_sel;
				mem_wdata_o <= push_byte;
			end
			if (mem_req_o && mem_ack_i) begin
				mem_req_o <= 1'b0;
				mem_we_o <= 1'b0;
				cnt_reg <= cnt_reg + 3'd1;
				case (st_reg)
					S_PUSH: begin
						stack_pointer_reg <= stack_pointer_reg - 16'h0001;
						if (cnt_reg == seq_len(kind_reg) - 3'd1) begin
							st_reg <= S_IDLE;
							if (kind_reg == `CPRF_C_SWI) begin
								condition_code_reg[`CPRF_B_I] <= 1'b1;
								st_reg <= S_VECH;
							end
							if (kind_reg == `CPRF_C_CALL)
								program_counter_reg <= tgt_reg;
						end
					end
					S_PULL: begin
						stack_pointer_reg <= stack_pointer_reg + 16'h0001;
						case ({kind_reg, cnt_reg})
							{`CPRF_C_IRET, 3'd0}: condition_code_reg <= mem_rdata_i | `CPRF_CCR_ONES;
							{`CPRF_C_IRET, 3'd1}, {`CPRF_C_PULA, 3'd0}: accumulator_reg <= mem_rdata_i;
							{`CPRF_C_IRET, 3'd2}: index_pair_reg[7:0] <= mem_rdata_i;
							{`CPRF_C_IRET, 3'd3}, {`CPRF_C_RET, 3'd0}: program_counter_reg[15:8] <= mem_rdata_i;
							{`CPRF_C_PULLX, 3'd0}: index_pair_reg[15:8] <= mem_rdata_i;
							default: program_counter_reg[7:0] <= mem_rdata_i;
						endcase
						if (cnt_reg == seq_len(kind_reg) - 3'd1)
							st_reg <= S_IDLE;
					end
					S_VECH: begin
						program_counter_reg[15:8] <= mem_rdata_i;
						st_reg <= S_VECL;
					end
					S_VECL: begin
						program_counter_reg[7:0] <= mem_rdata_i;
						st_reg <= S_IDLE;
					end
					S_FETCH: begin
						data_reg <= mem_rdata_i;
						program_counter_reg <= program_counter_reg + 16'h0001;
						st_reg <= S_IDLE;
					end
					default: st_reg <= S_IDLE;
				endcase
			end
		end
	end
endmodule // cprf_core

// ==== sim/cprf_core_props.sv ====
// assertion checker for the cpu register file core
`timescale 1ns/1ps
module cprf_core_props (
	// clock and reset
	input wire        clk_sys_i,
	input wire        sys_rst_i,
	// memory bus and state
	input wire        mem_req_o,
	input wire        mem_we_o,
	input wire [15:0] mem_addr_o,
	input wire        mem_ack_i,
	input wire        mask_o,
	// register bus answers
	input wire        s_axi_bvalid_o,
	input wire        s_axi_bready_i,
	input wire [1:0]  s_axi_bresp_o,
	input wire        s_axi_rvalid_o,
	input wire        s_axi_rready_i,
	input wire [31:0] s_axi_rdata_o,
	input wire        s_axi_arvalid_i,
	input wire        s_axi_arready_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence vec_hi_s;
		mem_req_o && !mem_we_o && mem_addr_o == 16'hFFFE;
	endsequence
	sequence vec_lo_s;
		mem_req_o && !mem_we_o && mem_addr_o == 16'hFFFF;
	endsequence
	reset_vec_a: assert property ($fell(sys_rst_i) |-> ##[0:2] vec_hi_s)
		else $error("reset vector fetch missing");
	vec_pair_a: assert property (vec_hi_s ##0 mem_ack_i |-> ##[1:4] vec_lo_s)
		else $error("reset vector low byte missing");
	rst_mask_a: assert property ($fell(sys_rst_i) |-> mask_o)
		else $error("mask clear after reset");
	vec_mask_a: assert property (mem_req_o && !mem_we_o && mem_addr_o >= 16'hFFEC |-> mask_o)
		else $error("vector fetched with mask clear");
	mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("memory request changed before ack");
	req_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("no gap between memory bytes");
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped early");
	read_ans_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
endmodule // cprf_core_props

bind cprf_core cprf_core_props cprf_core_props_i (.clk_sys_i, .sys_rst_i, .mem_req_o, .mem_we_o, .mem_addr_o,
	.mem_ack_i, .mask_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.s_axi_rdata_o, .s_axi_arvalid_i, .s_axi_arready_o);

// ==== sim/cprf_mem_model.sv ====
// byte memory model on the core's internal bus
`timescale 1ns/1ps
module cprf_mem_model (
	// clock and stall select
	input  wire        clk_sys_i,
	input  wire        slow_i,
	// memory bus
	input  wire        req_i,
	input  wire        we_i,
	input  wire [15:0] addr_i,
	input  wire [7:0]  wdata_i,
	output reg  [7:0]  rdata_o,
	output reg         ack_o
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_reg;
	initial begin
		ack_o = 1'b0;
		rdata_o = 8'h00;
		wait_reg = 2'd0;
	end
	// data is scrambled between requests so a stale byte never looks valid
	always @(posedge clk_sys_i) begin
		ack_o <= 1'b0;
		if (!req_i)
			rdata_o <= ~rdata_o;
		else if (!ack_o) begin
			if (slow_i && wait_reg != 2'd3)
				wait_reg <= wait_reg + 2'd1;
			else begin
				wait_reg <= 2'd0;
				ack_o <= 1'b1;
				rdata_o <= mem[addr_i];
				if (we_i)
					mem[addr_i] <= wdata_i;
			end
		end
	end
endmodule // cprf_mem_model

// ==== sim/cpu_registers_and_flags_test.sv ====
// self-checking bench for the cpu register file core
`timescale 1ns/1ps
module cpu_registers_and_flags_test;
	logic        clk_sys_i = 0, sys_rst_i = 1, ce_i = 1, slow = 0;
	logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
	logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, irq_i = 0;
	logic [31:0] s_axi_wdata_i = 0;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	wire  [31:0] s_axi_rdata_o;
	wire         mem_req_o, mem_we_o, mem_ack_i, busy_o, mask_o;
	wire  [15:0] mem_addr_o;
	wire  [7:0]  mem_wdata_o, mem_rdata_i;
	int          n_mismatch = 0, checks = 0;
	cprf_core cprf_core_i (.clk_sys_i, .sys_rst_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i,
		.mem_ack_i, .irq_i, .busy_o, .mask_o);
	cprf_mem_model cprf_mem_model_i (.clk_sys_i(clk_sys_i), .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
	always #4 clk_sys_i = ~clk_sys_i;
	task test_done;
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er = 2'b00);
		int n;
		n = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1 && n < 200);
		s_axi_bready_i <= 1'b0;
		if (n >= 200) n_mismatch++;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
	endtask
	task rc(input [7:0] a, input [31:0] e, input [1:0] er = 2'b00);
		int n;
		n = 0;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1 && n < 200);
		s_axi_rready_i <= 1'b0;
		if (n >= 200) n_mismatch++;
		chk($sformatf("reg %h", a), e, s_axi_rdata_o);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
	endtask
	task idle;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (busy_o !== 1'b0 && n < 500);
		if (n >= 500) n_mismatch++;
	endtask
	// commands written while busy are dropped, so wait for idle on both sides
	task cm(input [3:0] op, input [3:0] sb, input [15:0] v);
		idle;
		wr(8'h14, {8'h00, v, sb, op});
		idle;
	endtask
	task alu(input [7:0] a, input [7:0] b, input [7:0] r, input [7:0] f);
		cm(4'h1, 4'hC, {8'h00, a});
		cm(4'h1, 4'h0, {8'h00, b});
		rc(8'h00, {24'h0, r});
		rc(8'h10, {24'h0, f});
	endtask
	task mc(input [15:0] a, input [7:0] e);
		chk("stack byte", {24'h0, e}, {24'h0, cprf_mem_model_i.mem[a]});
	endtask
	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
	initial begin
		cprf_mem_model_i.mem[16'hFFFE] = 8'h12;
		cprf_mem_model_i.mem[16'hFFFF] = 8'h34;
		cprf_mem_model_i.mem[16'hFFF8] = 8'h60;
		cprf_mem_model_i.mem[16'hFFF9] = 8'h00;
		cprf_mem_model_i.mem[16'h4000] = 8'h3C;
		repeat (4) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		idle;
		rc(8'h08, 32'h00FF);
		rc(8'h0C, 32'h1234);
		rc(8'h10, 32'h68);
		rc(8'h18, 32'h2);
		alu(8'h0F, 8'h01, 8'h10, 8'h78);
		alu(8'h7F, 8'h01, 8'h80, 8'hFC);
		alu(8'h80, 8'h80, 8'h00, 8'hEB);
		alu(8'hFF, 8'h01, 8'h00, 8'h7B);
		wr(8'h00, 32'hA5);
		rc(8'h00, 32'hA5);
		wr(8'h04, 32'hAB12);
		rc(8'h04, 32'hAB12);
		cm(4'hF, 4'h0, 16'h0010);
		rc(8'h1C, 32'hAB22);
		cm(4'hF, 4'h1, 16'h0010);
		rc(8'h1C, 32'h010F);
		wr(8'h10, 32'h0);
		rc(8'h10, 32'h68);
		cm(4'hB, 4'h0, 16'h0);
		mc(16'h00FF, 8'hA5);
		rc(8'h08, 32'h00FE);
		wr(8'h00, 32'h0);
		cm(4'hC, 4'h0, 16'h0);
		rc(8'h00, 32'hA5);
		rc(8'h08, 32'h00FF);
		wr(8'h08, 32'h1234);
		cm(4'h5, 4'h0, 16'h0);
		rc(8'h08, 32'h12FF);
		wr(8'h08, 32'h00FF);
		cm(4'h3, 4'h0, 16'h4000);
		rc(8'h0C, 32'h4000);
		cm(4'h2, 4'h0, 16'h0);
		rc(8'h0C, 32'h4001);
		rc(8'h20, 32'h3C);
		cm(4'h7, 4'h0, 16'h5000);
		rc(8'h08, 32'h00FD);
		rc(8'h0C, 32'h5000);
		cm(4'h8, 4'h0, 16'h0);
		rc(8'h0C, 32'h4001);
		rc(8'h24, 32'h0, 2'b10);
		wr(8'h18, 32'h0, 2'b10);
		irq_i <= 8'h06;
		repeat (8) @(posedge clk_sys_i);
		rc(8'h18, 32'h1802);
		rc(8'h0C, 32'h4001);
		slow <= 1'b1;
		cm(4'h6, 4'h0, 16'h0);
		repeat (4) @(posedge clk_sys_i);
		idle;
		rc(8'h0C, 32'h6000);
		rc(8'h08, 32'h00FA);
		rc(8'h18, 32'h1802);
		mc(16'h00FF, 8'h01);
		mc(16'h00FE, 8'h40);
		mc(16'h00FD, 8'h12);
		mc(16'h00FC, 8'hA5);
		chk("stacked mask", 32'h0, {31'h0, cprf_mem_model_i.mem[16'h00FB][3]});
		irq_i <= 8'h00;
		repeat (4) @(posedge clk_sys_i);
		cm(4'hA, 4'h0, 16'h0);
		rc(8'h0C, 32'h4001);
		rc(8'h08, 32'h00FF);
		rc(8'h18, 32'h0);
		cm(4'h4, 4'h2, 16'h0010);
		rc(8'h0C, 32'h4001);
		cm(4'h4, 4'h1, 16'h0010);
		rc(8'h0C, 32'h4011);
		cm(4'h4, 4'h3, 16'h00F0);
		rc(8'h0C, 32'h4001);
		test_done;
	end
endmodule // cpu_registers_and_flags_test
